// file: tb/hdlc3_msg_byte_count_tb.sv
/*
 * Self-checking bench for the third data link message count block.
 * Assumes the design files and the link partner model are compiled first.
 */
`timescale 1ns/1ns
module hdlc3_msg_byte_count_tb;
	logic                          core_clk = 1'b0;
	logic                          sys_rst = 1'b1;
	logic                          psel = 1'b0;
	logic                          penable = 1'b0;
	logic                          pwrite = 1'b0;
	logic [7:0]                    paddr = 8'h00;
	logic [31:0]                   pwdata = 32'h00000000;
	logic                          pready;
	logic [31:0]                   prdata;
	logic                          pslverr;
	hdlc3_count_pkg::rx_report_type rx_report;
	logic                          tx_msg_done;
	hdlc3_count_pkg::tx_cmd_type   tx_cmd;
	logic                          irq;
	int                            n_errors = 0;
	int                            total_checks = 0;
	int                            p0;
	logic [31:0]                   r;
	logic                          e;

	always #50 core_clk = ~core_clk;

	hdlc3_msg_byte_count hdlc3_msg_byte_count_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_report(rx_report),
		.tx_msg_done(tx_msg_done), .tx_cmd(tx_cmd), .irq(irq));

	link_partner_model link_partner_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.tx_cmd(tx_cmd), .rx_report(rx_report), .tx_msg_done(tx_msg_done));

	task final_report;
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer: setup, then access held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			n_errors++;
			$display("Error at %0t: no pready", $time);
			final_report;
		end
	endtask

	task automatic wait_on(input bit want_irq);
		int n;
		for (n = 0; n < 400; n++) begin
			@(negedge core_clk);
			if (want_irq ? irq === 1'b1 : tx_cmd.active === 1'b0) break;
		end
		if (n == 400) begin
			n_errors++;
			$display("Error at %0t: wait timed out", $time);
			final_report;
		end
	endtask

	task t_reset_and_map;
		apb(1'b0, hdlc3_count_pkg::RX_COUNT_PTR_ADDR, 32'h00000000);
		chk(r, 32'h00000000);
		apb(1'b0, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000000);
		chk(r, 32'h00000000);
		chk(irq, 1'b0);
		apb(1'b1, 8'h14, 32'h000000FF);
		chk(e, 1'b1);
		apb(1'b0, 8'h14, 32'h00000000);
		chk({e, r}, {1'b1, 32'h00000000});
	endtask

	task t_tx_reps;
		apb(1'b1, hdlc3_count_pkg::CONTROL_ADDR, 32'h00000001);
		apb(1'b1, hdlc3_count_pkg::IRQ_MASK_ADDR, 32'h00000001);
		p0 = link_partner_model_i.pulses;
		apb(1'b1, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000003);
		wait_on(1'b0);
		chk(link_partner_model_i.pulses - p0, 3);
		@(negedge core_clk);
		chk(irq, 1'b1);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000001);
		p0 = link_partner_model_i.pulses;
		apb(1'b1, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000000);
		repeat (60) @(negedge core_clk);
		chk(tx_cmd.active, 1'b1);
		chk(link_partner_model_i.pulses - p0 > 15, 1'b1);
		apb(1'b1, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000001);
		wait_on(1'b0);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000001);
	endtask

	task t_tx_msg;
		apb(1'b1, hdlc3_count_pkg::CONTROL_ADDR, 32'h00000000);
		link_partner_model_i.gap = 30;
		apb(1'b1, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000085);
		@(negedge core_clk);
		chk(tx_cmd, {1'b1, 1'b0, 1'b1, 7'h05});
		apb(1'b0, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000000);
		chk(r, 32'h00000005);
		wait_on(1'b0);
		apb(1'b1, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h0000007F);
		apb(1'b0, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000000);
		chk(r, 32'h000000FF);
		wait_on(1'b0);
		apb(1'b0, hdlc3_count_pkg::TX_COUNT_SEL_ADDR, 32'h00000000);
		chk(r, 32'h0000007F);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000001);
	endtask

	task t_rx_msg;
		apb(1'b1, hdlc3_count_pkg::IRQ_MASK_ADDR, 32'h00000004);
		link_partner_model_i.rx_event(1'b1, 1'b1, 7'h09);
		wait_on(1'b1);
		apb(1'b0, hdlc3_count_pkg::RX_COUNT_PTR_ADDR, 32'h00000000);
		chk(r, 32'h00000089);
		link_partner_model_i.rx_event(1'b1, 1'b1, 7'h11);
		link_partner_model_i.rx_event(1'b1, 1'b0, 7'h7F);
		apb(1'b0, hdlc3_count_pkg::RX_COUNT_PTR_ADDR, 32'h00000000);
		chk(r, 32'h0000007F);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000004);
	endtask

	task t_rx_reps;
		apb(1'b1, hdlc3_count_pkg::CONTROL_ADDR, 32'h00000002);
		apb(1'b1, hdlc3_count_pkg::IRQ_MASK_ADDR, 32'h00000002);
		apb(1'b1, hdlc3_count_pkg::RX_COUNT_PTR_ADDR, 32'h00000002);
		link_partner_model_i.rx_event(1'b0, 1'b0, 7'h00);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000000);
		link_partner_model_i.rx_event(1'b0, 1'b0, 7'h00);
		wait_on(1'b1);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000002);
		apb(1'b1, hdlc3_count_pkg::RX_COUNT_PTR_ADDR, 32'h00000000);
		repeat (5) link_partner_model_i.rx_event(1'b0, 1'b0, 7'h00);
		repeat (3) @(negedge core_clk);
		chk(irq, 1'b0);
		apb(1'b0, hdlc3_count_pkg::IRQ_STATUS_ADDR, 32'h00000000);
		chk(r, 32'h00000000);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset_and_map;
		t_tx_reps;
		t_tx_msg;
		t_rx_msg;
		t_rx_reps;
		final_report;
	end
endmodule

// file: tb/link_partner_model.sv
/*
 * Behavioural far end of the third data link: answers transmit transfers with
 * done pulses and delivers receive events on request from the bench.
 * Assumes the single core clock and the synchronous active-high reset.
 */
`timescale 1ns/1ns
module link_partner_model (
	// Clock and reset.
	input  wire logic                           core_clk,
	input  wire logic                           sys_rst,
	// Link side of the block.
	input  wire hdlc3_count_pkg::tx_cmd_type    tx_cmd,
	output hdlc3_count_pkg::rx_report_type      rx_report,
	output logic                                tx_msg_done
);
	int gap = 2;
	int pulses = 0;
	int wait_cnt = 0;

	initial begin
		rx_report = '0;
		tx_msg_done = 1'b0;
	end

	// Sends one repetition or message per gap while the transfer is active.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			tx_msg_done <= 1'b0;
			wait_cnt <= 0;
		end else begin
			tx_msg_done <= 1'b0;
			if (tx_cmd.active && !tx_msg_done && wait_cnt >= gap) begin
				tx_msg_done <= 1'b1;
				pulses <= pulses + 1;
				wait_cnt <= 0;
			end else if (tx_cmd.active) begin
				wait_cnt <= wait_cnt + 1;
			end else begin
				wait_cnt <= 0;
			end
		end
	end

	// Pulses one receive event; idle fields then carry the inverse of the last value.
	task rx_event(input logic msg, input logic buf_sel, input logic [6:0] n);
		@(posedge core_clk);
		rx_report <= '{msg_done: msg, rep_seen: !msg, buffer: buf_sel, bytes: n};
		@(posedge core_clk);
		rx_report <= '{msg_done: 1'b0, rep_seen: 1'b0, buffer: ~buf_sel, bytes: ~n};
	endtask
endmodule

// file: verilog/hdlc3_count_pkg.sv
/*
 * Constants and carrier types for the third data link message count block.
 * Assumes a single 10 MHz core clock and an APB register port with byte addresses.
 */
package hdlc3_count_pkg;
	localparam int COUNT_W = 7;
	localparam int ADDR_W  = 8;
	localparam int IRQ_W   = 3;

	localparam logic [ADDR_W-1:0] RX_COUNT_PTR_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] TX_COUNT_SEL_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] CONTROL_ADDR      = 8'h08;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR   = 8'h0C;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR     = 8'h10;

	localparam int PTR_BIT     = 7;
	localparam int SEL_BIT     = 7;
	localparam int TX_MODE_BIT = 0;
	localparam int RX_MODE_BIT = 1;
	localparam int IRQ_TX_EOT  = 0;
	localparam int IRQ_RX_EOT  = 1;
	localparam int IRQ_RX_MSG  = 2;

	localparam logic [COUNT_W-1:0] COUNT_RESET     = 7'h00;
	localparam logic [COUNT_W-1:0] COUNT_UNLIMITED = 7'h00;
	localparam logic [COUNT_W-1:0] COUNT_ONE       = 7'h01;
	localparam logic [1:0]         MODE_RESET      = 2'h0;
	localparam logic [1:0]         BUSY_RESET      = 2'h0;
	localparam logic [IRQ_W-1:0]   IRQ_RESET       = 3'h0;
	localparam logic [31:0]        WORD_ZERO       = 32'h00000000;

	typedef struct packed {
		logic               msg_done;
		logic               rep_seen;
		logic               buffer;
		logic [COUNT_W-1:0] bytes;
	} rx_report_type;

	typedef struct packed {
		logic               active;
		logic               bit_mode;
		logic               buffer;
		logic [COUNT_W-1:0] length;
	} tx_cmd_type;
endpackage

// file: verilog/hdlc3_msg_byte_count.sv
/*
 * Transmit and receive message count, buffer select and buffer pointer logic
 * of the third data link controller, with APB registers and one interrupt.
 * Assumes the framing logic reports message events as one-cycle pulses.
 */
// Contract
// - Bit mode transmit repeats count times, stops, interrupts.
// - Zero transmit count repeats without limit.
// - Message mode transmit count excludes FCS.
// - Receive pointer names buffer holding newest message.
// - Bit mode receive interrupts after count repetitions.
// - Zero receive count never interrupts.
// - Message mode receive count includes FCS.
// - Write selects transmit buffer, read shows free.
`timescale 1ns/1ns
module hdlc3_msg_byte_count (
	// Clock and reset.
	input  wire logic                                 core_clk,
	input  wire logic                                 sys_rst,
	// APB slave.
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [hdlc3_count_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                          pwdata,
	output logic                                      pready,
	output logic [31:0]                               prdata,
	output logic                                      pslverr,
	// Link controller side.
	input  wire hdlc3_count_pkg::rx_report_type       rx_report,
	input  wire logic                                 tx_msg_done,
	output hdlc3_count_pkg::tx_cmd_type               tx_cmd,
	// Interrupt.
	output logic                                      irq
);
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;

	tx_state_type                         tx_state_ff;
	tx_state_type                         nxt_tx_state;
	logic [hdlc3_count_pkg::COUNT_W-1:0]  tx_count_ff;
	logic [hdlc3_count_pkg::COUNT_W-1:0]  nxt_tx_count;
	logic                                 tx_sel_ff;
	logic                                 nxt_tx_sel;
	logic [1:0]                           tx_busy_ff;
	logic [1:0]                           nxt_tx_busy;
	logic [hdlc3_count_pkg::COUNT_W-1:0]  rx_count_ff;
	logic [hdlc3_count_pkg::COUNT_W-1:0]  nxt_rx_count;
	logic                                 rx_ptr_ff;
	logic                                 nxt_rx_ptr;
	logic                                 rx_pend_ff;
	logic                                 nxt_rx_pend;
	logic [1:0]                           mode_ff;
	logic [1:0]                           nxt_mode;
	logic [hdlc3_count_pkg::IRQ_W-1:0]    irq_status_ff;
	logic [hdlc3_count_pkg::IRQ_W-1:0]    nxt_irq_status;
	logic [hdlc3_count_pkg::IRQ_W-1:0]    irq_mask_ff;
	logic [hdlc3_count_pkg::IRQ_W-1:0]    nxt_irq_mask;
	logic [31:0]                          prdata_ff;
	logic [31:0]                          nxt_prdata;
	logic                                 pslverr_ff;
	logic                                 nxt_pslverr;

	logic                                 setup;
	logic                                 wr_en;
	logic                                 rd_en;
	logic                                 tx_start;
	logic                                 tx_bit_mode;
	logic                                 rx_bit_mode;
	logic                                 tx_step;
	logic                                 tx_rep_reached;
	logic                                 tx_finish;
	logic                                 rx_step;
	logic                                 rx_clear;
	logic                                 rx_rep_reached;
	logic                                 rx_msg_load;
	logic                                 tx_avail;
	logic [hdlc3_count_pkg::IRQ_W-1:0]    irq_set;

	// Returns true when the address names one of the registers.
	function automatic logic addr_mapped(input logic [hdlc3_count_pkg::ADDR_W-1:0] addr);
		addr_mapped = (addr == hdlc3_count_pkg::RX_COUNT_PTR_ADDR) ||
		              (addr == hdlc3_count_pkg::TX_COUNT_SEL_ADDR) ||
		              (addr == hdlc3_count_pkg::CONTROL_ADDR) ||
		              (addr == hdlc3_count_pkg::IRQ_STATUS_ADDR) ||
		              (addr == hdlc3_count_pkg::IRQ_MASK_ADDR);
	endfunction

	// The slave never inserts wait states; read data is captured in setup.
	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && addr_mapped(paddr);
	assign rd_en   = psel && penable && !pwrite;

	assign tx_bit_mode = mode_ff[hdlc3_count_pkg::TX_MODE_BIT];
	assign rx_bit_mode = mode_ff[hdlc3_count_pkg::RX_MODE_BIT];
	assign tx_start = wr_en && (paddr == hdlc3_count_pkg::TX_COUNT_SEL_ADDR);
	assign tx_step  = (tx_state_ff == TX_SEND) && tx_bit_mode && tx_msg_done;
	assign tx_finish = (tx_state_ff == TX_SEND) &&
	                   ((tx_bit_mode && tx_rep_reached) || (!tx_bit_mode && tx_msg_done));
	assign rx_step  = rx_bit_mode && rx_report.rep_seen;
	assign rx_clear = !rx_bit_mode || (wr_en && (paddr == hdlc3_count_pkg::RX_COUNT_PTR_ADDR));
	assign rx_msg_load = rx_report.msg_done && !rx_bit_mode;
	assign tx_avail = tx_busy_ff[0] && !tx_busy_ff[1];

	repeat_counter u_tx_reps (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clear    (tx_start),
		.step     (tx_step),
		.limit    (tx_count_ff),
		.reached  (tx_rep_reached)
	);

	repeat_counter u_rx_reps (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clear    (rx_clear),
		.step     (rx_step),
		.limit    (rx_count_ff),
		.reached  (rx_rep_reached)
	);

	// Transmit control and buffer bookkeeping.
	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_count = tx_count_ff;
		nxt_tx_sel   = tx_sel_ff;
		nxt_tx_busy  = tx_busy_ff;
		if (tx_finish) begin
			nxt_tx_state = TX_IDLE;
			nxt_tx_busy[tx_sel_ff] = 1'b0;
		end
		if (tx_start) begin
			nxt_tx_state = TX_SEND;
			nxt_tx_count = pwdata[hdlc3_count_pkg::COUNT_W-1:0];
			nxt_tx_sel   = pwdata[hdlc3_count_pkg::SEL_BIT];
			nxt_tx_busy[pwdata[hdlc3_count_pkg::SEL_BIT]] = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_state_ff <= TX_IDLE;
			tx_count_ff <= hdlc3_count_pkg::COUNT_RESET;
			tx_sel_ff   <= 1'b0;
			tx_busy_ff  <= hdlc3_count_pkg::BUSY_RESET;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_count_ff <= nxt_tx_count;
			tx_sel_ff   <= nxt_tx_sel;
			tx_busy_ff  <= nxt_tx_busy;
		end
	end

	assign tx_cmd.active   = (tx_state_ff == TX_SEND);
	assign tx_cmd.bit_mode = tx_bit_mode;
	assign tx_cmd.buffer   = tx_sel_ff;
	assign tx_cmd.length   = tx_count_ff;

	// Receive count and pointer; the link update wins over a software write.
	always_comb begin
		nxt_rx_count = rx_count_ff;
		nxt_rx_ptr   = rx_ptr_ff;
		nxt_rx_pend  = rx_msg_load;
		if (wr_en && (paddr == hdlc3_count_pkg::RX_COUNT_PTR_ADDR)) begin
			nxt_rx_count = pwdata[hdlc3_count_pkg::COUNT_W-1:0];
			nxt_rx_ptr   = pwdata[hdlc3_count_pkg::PTR_BIT];
		end
		if (rx_report.msg_done) begin
			nxt_rx_ptr = rx_report.buffer;
		end
		if (rx_msg_load) begin
			nxt_rx_count = rx_report.bytes;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_count_ff <= hdlc3_count_pkg::COUNT_RESET;
			rx_ptr_ff   <= 1'b0;
			rx_pend_ff  <= 1'b0;
		end else begin
			rx_count_ff <= nxt_rx_count;
			rx_ptr_ff   <= nxt_rx_ptr;
			rx_pend_ff  <= nxt_rx_pend;
		end
	end

	// Mode, interrupt and read data registers.
	always_comb begin
		irq_set = hdlc3_count_pkg::IRQ_RESET;
		irq_set[hdlc3_count_pkg::IRQ_TX_EOT] = tx_finish;
		irq_set[hdlc3_count_pkg::IRQ_RX_EOT] = rx_rep_reached;
		irq_set[hdlc3_count_pkg::IRQ_RX_MSG] = rx_pend_ff;
		nxt_mode       = mode_ff;
		nxt_irq_mask   = irq_mask_ff;
		nxt_irq_status = irq_status_ff;
		nxt_prdata     = prdata_ff;
		nxt_pslverr    = pslverr_ff;
		if (wr_en && (paddr == hdlc3_count_pkg::CONTROL_ADDR)) begin
			nxt_mode = pwdata[1:0];
		end
		if (wr_en && (paddr == hdlc3_count_pkg::IRQ_MASK_ADDR)) begin
			nxt_irq_mask = pwdata[hdlc3_count_pkg::IRQ_W-1:0];
		end
		// Only the bits that were returned are cleared, and a new event wins.
		if (rd_en && (paddr == hdlc3_count_pkg::IRQ_STATUS_ADDR)) begin
			nxt_irq_status = irq_status_ff & ~prdata_ff[hdlc3_count_pkg::IRQ_W-1:0];
		end
		nxt_irq_status = nxt_irq_status | irq_set;
		if (setup) begin
			nxt_pslverr = !addr_mapped(paddr);
			nxt_prdata  = hdlc3_count_pkg::WORD_ZERO;
			case (paddr)
				hdlc3_count_pkg::RX_COUNT_PTR_ADDR: begin
					nxt_prdata[7:0] = {rx_ptr_ff, rx_count_ff};
				end
				hdlc3_count_pkg::TX_COUNT_SEL_ADDR: begin
					nxt_prdata[7:0] = {tx_avail, tx_count_ff};
				end
				hdlc3_count_pkg::CONTROL_ADDR: begin
					nxt_prdata[1:0] = mode_ff;
				end
				hdlc3_count_pkg::IRQ_STATUS_ADDR: begin
					nxt_prdata[hdlc3_count_pkg::IRQ_W-1:0] = irq_status_ff;
				end
				hdlc3_count_pkg::IRQ_MASK_ADDR: begin
					nxt_prdata[hdlc3_count_pkg::IRQ_W-1:0] = irq_mask_ff;
				end
				default: begin
					nxt_prdata = hdlc3_count_pkg::WORD_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_ff       <= hdlc3_count_pkg::MODE_RESET;
			irq_mask_ff   <= hdlc3_count_pkg::IRQ_RESET;
			irq_status_ff <= hdlc3_count_pkg::IRQ_RESET;
			prdata_ff     <= hdlc3_count_pkg::WORD_ZERO;
			pslverr_ff    <= 1'b0;
		end else begin
			mode_ff       <= nxt_mode;
			irq_mask_ff   <= nxt_irq_mask;
			irq_status_ff <= nxt_irq_status;
			prdata_ff     <= nxt_prdata;
			pslverr_ff    <= nxt_pslverr;
		end
	end

	assign irq = |(irq_status_ff & irq_mask_ff);

	// Checks on the design's own behaviour.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_tx_reps_stop: assert property (
		tx_step && tx_rep_reached && !tx_start |=>
		(tx_state_ff == TX_IDLE) && irq_status_ff[hdlc3_count_pkg::IRQ_TX_EOT])
		else $error("Transmit did not stop after the last repetition.");
	a_tx_no_limit: assert property (
		(tx_state_ff == TX_SEND) && tx_bit_mode &&
		(tx_count_ff == hdlc3_count_pkg::COUNT_UNLIMITED) |=> tx_state_ff == TX_SEND)
		else $error("Unlimited transmit ended.");
	a_tx_msg_end: assert property (
		(tx_state_ff == TX_SEND) && !tx_bit_mode && tx_msg_done && !tx_start |=>
		(tx_state_ff == TX_IDLE) && (tx_cmd.length == $past(tx_count_ff)))
		else $error("Message transmit did not end on completion.");
	a_rx_ptr_track: assert property (
		rx_report.msg_done |=> rx_ptr_ff == $past(rx_report.buffer))
		else $error("Receive pointer missed the newest buffer.");
	a_rx_eot_set: assert property (
		rx_rep_reached |=> irq_status_ff[hdlc3_count_pkg::IRQ_RX_EOT])
		else $error("Receive end of transfer was not flagged.");
	a_rx_zero_quiet: assert property (
		rx_bit_mode && (rx_count_ff == hdlc3_count_pkg::COUNT_UNLIMITED) |-> !rx_rep_reached)
		else $error("Receive end of transfer with zero count.");
	a_rx_len_load: assert property (
		rx_msg_load |=> rx_count_ff == $past(rx_report.bytes))
		else $error("Receive byte count not loaded.");
	a_tx_sel_busy: assert property (
		tx_start |=> tx_busy_ff[tx_sel_ff] &&
		(tx_sel_ff == $past(pwdata[hdlc3_count_pkg::SEL_BIT])))
		else $error("Selected transmit buffer not marked busy.");
	a_rx_order: assert property (
		rx_msg_load |=> rx_pend_ff && (rx_count_ff == $past(rx_report.bytes)) &&
		(rx_ptr_ff == $past(rx_report.buffer)) ##1 irq_status_ff[hdlc3_count_pkg::IRQ_RX_MSG])
		else $error("Message flag not set one cycle after the update.");
	a_status_sticky: assert property (
		irq_status_ff[hdlc3_count_pkg::IRQ_TX_EOT] && !rd_en |=>
		irq_status_ff[hdlc3_count_pkg::IRQ_TX_EOT])
		else $error("Transmit status bit cleared without a read.");

	c_tx_reps_done: cover property (tx_step && tx_rep_reached);
	c_rx_reps_done: cover property (rx_rep_reached);
	c_rx_msg_flag: cover property (rx_msg_load ##2 irq);
	c_tx_unlimited: cover property (tx_step && (tx_count_ff == hdlc3_count_pkg::COUNT_UNLIMITED));
	c_tx_msg_done: cover property (tx_finish && !tx_bit_mode);
endmodule

// file: verilog/repeat_counter.sv
/*
 * Counts repetitions of a message and pulses when a nonzero limit is met.
 * Assumes step is a single-cycle pulse in the core clock domain; clear may be held high for many cycles.
 */
`timescale 1ns/1ns
module repeat_counter (
	// Clock and reset.
	input  wire logic                               core_clk,
	input  wire logic                               sys_rst,
	// Control.
	input  wire logic                               clear,
	input  wire logic                               step,
	input  wire logic [hdlc3_count_pkg::COUNT_W-1:0] limit,
	// Result.
	output logic                                    reached
);
	logic [hdlc3_count_pkg::COUNT_W-1:0] count_ff;
	logic [hdlc3_count_pkg::COUNT_W-1:0] nxt_count;
	logic [hdlc3_count_pkg::COUNT_W-1:0] count_inc;

	assign count_inc = count_ff + hdlc3_count_pkg::COUNT_ONE;
	// A zero limit means no end, so no pulse is ever produced.
	assign reached = step && (limit != hdlc3_count_pkg::COUNT_UNLIMITED) && (count_inc == limit);

	always_comb begin
		nxt_count = count_ff;
		if (clear || reached) begin
			nxt_count = hdlc3_count_pkg::COUNT_RESET;
		end else if (step) begin
			nxt_count = count_inc;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_ff <= hdlc3_count_pkg::COUNT_RESET;
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule
